// ### arinc_receive_channel_tb_top.sv
// self-checking bench for the receive channel: register bus, line traffic, word checks
`timescale 1ns/10ps
module arinc_receive_channel_tb_top;
    ////////////////////////////////////////////////////////////////////////////////
    // clock, reset and bus master state
    logic        clk_sys     = 1'b0;
    logic        srst        = 1'b1;
    logic        hsel        = 1'b0;
    logic [31:0] haddr       = 32'h0000_0000;
    logic [1:0]  htrans      = 2'h0;
    logic        hwrite      = 1'b0;
    logic [2:0]  hsize       = 3'h2;
    logic [31:0] hwdata      = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    // lines and chip-level settings
    logic        rxOne, rxZero, tstOne, tstZero;
    logic        intEn       = 1'b1;
    logic        parSelf     = 1'b1;
    // towards the vector logic
    logic        irq, wordPending;
    logic [3:0]  prio;
    // bookkeeping
    int          n_mismatch  = 0;
    int          comparisons = 0;
    integer      seed        = 32'hf876;
    logic [31:0] rd, w, v;
    logic [7:0]  lab;

    // free-running system clock
    always #2.5 clk_sys = ~clk_sys;

    arx_receive_channel dut (
        .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxOneLine(rxOne),
        .rxZeroLine(rxZero), .testOneLine(tstOne), .testZeroLine(tstZero),
        .interruptEnable(intEn), .selfTestParityEn(parSelf),
        .receiveInterruptRequest(irq), .wordPending(wordPending), .channelPriority(prio));

    arx_line_model lm (.clk_sys(clk_sys), .oneLine(rxOne), .zeroLine(rxZero),
        .testOne(tstOne), .testZero(tstZero));

    ////////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // parity bit chosen so the word passes (good) or fails the odd or even check
    function automatic logic [31:0] withPar(input logic [31:0] x, input logic odd,
                                            input logic good);
        withPar    = {x[31:1], 1'b0};
        withPar[0] = (^withPar) ^ odd ^ ~good;
    endfunction : withPar

    // ready is sampled where it stands before the edge, so no race with the slave's flops
    task automatic waitRdy();
        logic r;
        forever begin
            @(negedge clk_sys);
            r  = hreadyout;
            rd = hrdata;
            @(posedge clk_sys);
            if (r === 1'b1) break;
        end
    endtask : waitRdy

    // one single word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [11:0] a, input logic [15:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h0_0000, a};
        hwrite <= wr;
        waitRdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0000, d};
        waitRdy();
    endtask : bus

    task automatic rdChk(input logic [11:0] a, input logic [15:0] exp);
        bus(1'b0, a, 16'h0000);
        chk(rd, {16'h0000, exp});
    endtask : rdChk

    // bounded wait for a buffered word; runs out quietly when none arrives
    task automatic waitPend();
        for (int i = 0; i < 1200; i++) begin
            @(posedge clk_sys);
            if (wordPending === 1'b1) break;
        end
        @(negedge clk_sys);
    endtask : waitPend

    task automatic getWord(input logic [31:0] x);
        rdChk(arx_pkg::OFS_BUF_MSW, x[31:16]);
        rdChk(arx_pkg::OFS_BUF_LSW, x[15:0]);
    endtask : getWord

    // send a word, expect it buffered or dropped, and drain it when buffered
    task automatic recv(input logic [31:0] x, input int n, input logic via, input logic acc);
        lm.send(x, n, via);
        waitPend();
        chk({31'h0, wordPending}, {31'h0, acc});
        if (acc) chk({31'h0, irq}, {31'h0, intEn});
        @(posedge clk_sys);
        if (acc) begin
            getWord(x);
            @(negedge clk_sys);
            chk({31'h0, wordPending}, 32'h0000_0000);
            @(posedge clk_sys);
        end
    endtask : recv

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence needs well under half this span
    initial begin
        #400000;
        n_mismatch++;
        results();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        chk({28'h0, prio}, 32'h0000_0000);
        chk({30'h0, wordPending, irq}, 32'h0000_0000);
        rdChk(arx_pkg::OFS_CONTROL, 16'h0000);
        rdChk(arx_pkg::OFS_STATUS, 16'h0000);
        bus(1'b1, 12'h0F0, 16'hFFFF);
        rdChk(12'h0F0, 16'h0000);
        bus(1'b1, arx_pkg::OFS_GAP, 16'h0003);
        rdChk(arx_pkg::OFS_GAP, 16'h0000);
        // unused bits and a set attempt on the parity flag must not stick
        bus(1'b1, arx_pkg::OFS_CONTROL, 16'h83F5);
        rdChk(arx_pkg::OFS_CONTROL, 16'h8005);
        chk({28'h0, prio}, 32'h0000_0005);
        for (int k = 0; k < 4; k++) begin
            w = $random(seed);
            intEn <= k[0];
            recv(w, 32, 1'b0, 1'b1);
        end
        w = $random(seed);
        recv(w, 31, 1'b0, 1'b0);
        recv(~w, 32, 1'b0, 1'b1);
        // both parity senses: a bad word sets the flag, a good one passes
        for (int s = 0; s < 2; s++) begin
            v = 32'h0000_8400 | (32'(s) << 11);
            bus(1'b1, arx_pkg::OFS_CONTROL, v[15:0]);
            w = withPar($random(seed), s[0], 1'b0);
            recv(w, 32, 1'b0, 1'b0);
            chk({31'h0, irq}, 32'h0000_0001);
            rdChk(arx_pkg::OFS_CONTROL, v[15:0] | 16'h0080);
            bus(1'b1, arx_pkg::OFS_CONTROL, v[15:0]);
            rdChk(arx_pkg::OFS_CONTROL, v[15:0]);
            recv(withPar(w, s[0], 1'b1), 32, 1'b0, 1'b1);
        end
        // with the self-test bit clear a bad word is still dropped but leaves no flag
        parSelf <= 1'b0;
        recv(w, 32, 1'b0, 1'b0);
        chk({31'h0, irq}, 32'h0000_0000);
        rdChk(arx_pkg::OFS_CONTROL, v[15:0]);
        parSelf <= 1'b1;
        // the neighbour label is written while matrix writes are blocked
        lab = 8'($random(seed));
        bus(1'b1, 12'h400 + {2'h0, lab ^ 8'h01, 2'h0}, 16'h0001);
        bus(1'b1, arx_pkg::OFS_CONTROL, 16'h9000);
        bus(1'b1, 12'h400 + {2'h0, lab, 2'h0}, 16'h0001);
        bus(1'b1, arx_pkg::OFS_CONTROL, 16'hA000);
        w = $random(seed);
        w[31:24] = lab;
        recv(w, 32, 1'b0, 1'b1);
        w[31:24] = lab ^ 8'h01;
        recv(w, 32, 1'b0, 1'b0);
        // a second word arrives while the buffer is full and waits for the read
        bus(1'b1, arx_pkg::OFS_CONTROL, 16'h8000);
        w = $random(seed);
        v = $random(seed);
        lm.send(w, 32, 1'b0);
        waitPend();
        @(posedge clk_sys);
        lm.send(v, 32, 1'b0);
        repeat (1200) @(posedge clk_sys);
        rdChk(arx_pkg::OFS_STATUS, 16'h0003);
        getWord(w);
        waitPend();
        @(posedge clk_sys);
        getWord(v);
        // test mode listens to the internal pair only
        bus(1'b1, arx_pkg::OFS_CONTROL, 16'hC000);
        recv(w, 32, 1'b1, 1'b1);
        recv(v, 32, 1'b0, 1'b0);
        bus(1'b1, arx_pkg::OFS_CONTROL, 16'h0000);
        recv(w, 32, 1'b0, 1'b0);
        chk({31'h0, hresp}, 32'h0000_0000);
        results();
    end
endmodule : arinc_receive_channel_tb_top

// ### arx_line_model.sv
// behavioural line demultiplexer: return-to-zero ones and zeros lines
`timescale 1ns/10ps
module arx_line_model (
    // clock
    input  wire logic clk_sys,
    // external pin pair
    output logic      oneLine,
    output logic      zeroLine,
    // third transmitter's internal pair
    output logic      testOne,
    output logic      testZero
);
    // lines rest at the null level between bits and between words
    initial {oneLine, zeroLine, testOne, testZero} = 4'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // one pulse per bit on exactly one line; the word's top bit goes first
    task automatic send(input logic [31:0] w, input int n, input logic viaTest);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            if (viaTest) begin
                testOne  <= w[31-i];
                testZero <= ~w[31-i];
            end else begin
                oneLine  <= w[31-i];
                zeroLine <= ~w[31-i];
            end
            repeat (8) @(posedge clk_sys);
            // back to null so the receiver sees a falling edge for every bit
            {oneLine, zeroLine, testOne, testZero} <= 4'h0;
            repeat (7) @(posedge clk_sys);
        end
    endtask : send
endmodule : arx_line_model

// ### arx_pkg.sv
// constants shared by the receive channel: register map, control fields, timing
package arx_pkg;

    // timing: system clock and the derived line-rate clock enable
    localparam int SYS_PERIOD_NS      = 5;
    localparam int LINE_CLK_PERIOD_NS = 1000;
    // longest period rounds down, never below one cycle
    localparam logic [7:0] LINE_DIV_CNT =
        8'((LINE_CLK_PERIOD_NS / SYS_PERIOD_NS) < 1 ? 1 : (LINE_CLK_PERIOD_NS / SYS_PERIOD_NS));

    // register byte offsets (low twelve address bits)
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_GAP     = 12'h004;
    localparam logic [11:0] OFS_BUF_MSW = 12'h008;
    localparam logic [11:0] OFS_BUF_LSW = 12'h00C;
    localparam logic [11:0] OFS_STATUS  = 12'h010;
    // label matrix window: one word per label, label in address bits 9..2
    localparam logic [1:0]  MATRIX_SPACE = 2'h1;

    // control register fields
    localparam int CTL_ENABLE    = 15;
    localparam int CTL_TEST      = 14;
    localparam int CTL_LABEL_CHK = 13;
    localparam int CTL_MATRIX_WE = 12;
    localparam int CTL_PAR_ODD   = 11;
    localparam int CTL_PAR_EN    = 10;
    localparam int CTL_WRONG_PAR = 7;
    localparam int CTL_PRIO_LSB  = 0;
    localparam int CTL_PRIO_W    = 4;
    // bits that a host write stores directly (15..10 and 3..0)
    localparam logic [15:0] CTL_WR_MASK = 16'hFC0F;
    localparam logic [15:0] CTL_RESET   = 16'h0000;
    localparam logic [15:0] GAP_RESET   = 16'h0010;

    // status register fields
    localparam int ST_FULL = 0;
    localparam int ST_HELD = 1;

    // word layout
    localparam logic [5:0] WORD_BITS = 6'h20;
    localparam logic [5:0] BITS_SAT  = 6'h21;
    localparam int LABEL_MSB = 31;
    localparam int LABEL_LSB = 24;
    localparam int HALF_W    = 16;

endpackage : arx_pkg

// ### arx_receive_channel.sv
// one serial receive channel with its AHB-Lite register slave
`timescale 1ns/10ps
module arx_receive_channel (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // serial line pins, return-to-zero
    input  wire logic        rxOneLine,
    input  wire logic        rxZeroLine,
    // third transmitter's internal lines for test mode
    input  wire logic        testOneLine,
    input  wire logic        testZeroLine,
    // chip-level settings
    input  wire logic        interruptEnable,
    input  wire logic        selfTestParityEn,
    // towards the interrupt and vector logic
    output logic             receiveInterruptRequest,
    output logic             wordPending,
    output logic [3:0]       channelPriority
);

    typedef struct packed {
        logic [7:0]  lineDiv;
        logic        lineTick;
        logic        bitClkPrev;
        logic [5:0]  bitCnt;
        logic [31:0] shiftReg;
        logic [15:0] gapCnt;
        logic        gapRun;
        logic        eomPulse;
        logic [15:0] control;
        logic [15:0] gapValue;
        logic [31:0] bufWord;
        logic        bufFull;
        logic        heldValid;
        logic        wrPend;
        logic        rdPend;
        logic [11:0] accAddr;
        logic [31:0] rdData;
    } arx_state_t;

    arx_state_t s_r;
    arx_state_t s_nxt;
    logic       labelMatrix [256];
    logic [1:0] lineSync;
    logic       selOne;
    logic       selZero;
    logic       bitClk;
    logic       bitRise;
    logic       bitFall;
    logic       parityOk;
    logic       labelOk;
    logic       wordOk;
    logic       accept;
    logic [7:0] accLabel;
    logic       matrixHit;

    ////////////////////////////////////////////////////////////////////////
    // line inputs: pins cross in through two flops, test lines are local
    arx_sync2 #(.WIDTH(2)) u_line_sync (
        .clk_sys (clk_sys),
        .srst    (srst),
        .asyncIn ({rxOneLine, rxZeroLine}),
        .syncOut (lineSync)
    );

    // input select and rebuilt bit clock: either line high means a bit cell
    assign selOne  = s_r.control[arx_pkg::CTL_TEST] ? testOneLine  : lineSync[1];
    assign selZero = s_r.control[arx_pkg::CTL_TEST] ? testZeroLine : lineSync[0];
    assign bitClk  = selOne | selZero;
    assign bitRise = bitClk & ~s_r.bitClkPrev;
    assign bitFall = ~bitClk & s_r.bitClkPrev;

    // acceptance checks, evaluated while the shift register is quiet
    assign parityOk = ~s_r.control[arx_pkg::CTL_PAR_EN] ||
        (s_r.control[arx_pkg::CTL_PAR_ODD] ? (^s_r.shiftReg) : ~(^s_r.shiftReg));
    assign labelOk  = ~s_r.control[arx_pkg::CTL_LABEL_CHK] ||
        labelMatrix[s_r.shiftReg[arx_pkg::LABEL_MSB:arx_pkg::LABEL_LSB]];
    assign wordOk   = (s_r.bitCnt == arx_pkg::WORD_BITS) && parityOk && labelOk;

    // bus decode
    assign accept    = hsel & htrans[1] & hready;
    assign accLabel  = s_r.accAddr[9:2];
    assign matrixHit = (s_r.accAddr[11:10] == arx_pkg::MATRIX_SPACE);

    ////////////////////////////////////////////////////////////////////////
    // next state: bus effects first so that hardware sets win over clears
    always_comb begin
        s_nxt          = s_r;
        s_nxt.lineTick = 1'b0;
        s_nxt.eomPulse = 1'b0;
        s_nxt.wrPend   = 1'b0;
        s_nxt.rdPend   = 1'b0;
        s_nxt.bitClkPrev = bitClk;

        // line-rate clock enable from a divider
        if (s_r.lineDiv == arx_pkg::LINE_DIV_CNT - 8'h01) begin
            s_nxt.lineDiv  = 8'h00;
            s_nxt.lineTick = 1'b1;
        end else begin
            s_nxt.lineDiv = s_r.lineDiv + 8'h01;
        end

        // write data phase
        if (s_r.wrPend) begin
            if (s_r.accAddr == arx_pkg::OFS_CONTROL) begin
                s_nxt.control = (hwdata[15:0] & arx_pkg::CTL_WR_MASK) |
                                (s_r.control & ~arx_pkg::CTL_WR_MASK);
                // flag clears only on a written 0
                s_nxt.control[arx_pkg::CTL_WRONG_PAR] = s_r.control[arx_pkg::CTL_WRONG_PAR] &
                    hwdata[arx_pkg::CTL_WRONG_PAR];
            end else if (s_r.accAddr == arx_pkg::OFS_GAP) begin
                s_nxt.gapValue = hwdata[15:0];
            end
        end

        // read wait cycle: sample after any earlier write has landed
        if (s_r.rdPend) begin
            s_nxt.rdData = 32'h0000_0000;
            if (s_r.accAddr == arx_pkg::OFS_CONTROL) begin
                s_nxt.rdData[15:0] = s_r.control;
            end else if (s_r.accAddr == arx_pkg::OFS_BUF_MSW) begin
                s_nxt.rdData[15:0] = s_r.bufWord[31:arx_pkg::HALF_W];
            end else if (s_r.accAddr == arx_pkg::OFS_BUF_LSW) begin
                s_nxt.rdData[15:0] = s_r.bufWord[arx_pkg::HALF_W-1:0];
                s_nxt.bufFull      = 1'b0;
            end else if (s_r.accAddr == arx_pkg::OFS_STATUS) begin
                s_nxt.rdData[arx_pkg::ST_FULL] = s_r.bufFull;
                s_nxt.rdData[arx_pkg::ST_HELD] = s_r.heldValid;
            end else if (matrixHit) begin
                s_nxt.rdData[0] = labelMatrix[accLabel];
            end
        end

        // address phase capture
        if (accept) begin
            s_nxt.wrPend  = hwrite;
            s_nxt.rdPend  = ~hwrite;
            s_nxt.accAddr = haddr[11:0];
        end

        if (!s_r.control[arx_pkg::CTL_ENABLE]) begin
            // out of service: no framing, nothing held
            s_nxt.bitCnt    = 6'h00;
            s_nxt.gapCnt    = 16'h0000;
            s_nxt.gapRun    = 1'b0;
            s_nxt.heldValid = 1'b0;
        end else begin
            // shift on each rising edge, ones line gives the bit value
            if (bitRise) begin
                s_nxt.shiftReg  = {s_r.shiftReg[30:0], selOne};
                s_nxt.bitCnt    = (s_r.bitCnt == arx_pkg::BITS_SAT) ? s_r.bitCnt
                                                                    : s_r.bitCnt + 6'h01;
                s_nxt.heldValid = 1'b0;
            end
            // gap counting restarts after every bit
            if (bitFall) begin
                s_nxt.gapCnt = 16'h0000;
                s_nxt.gapRun = 1'b1;
            end else if (s_r.gapRun && s_r.lineTick) begin
                s_nxt.gapCnt = s_r.gapCnt + 16'h0001;
                if (s_r.gapCnt + 16'h0001 == s_r.gapValue) begin
                    s_nxt.gapRun   = 1'b0;
                    s_nxt.eomPulse = 1'b1;
                end
            end
            // end of message: judge the word, then re-arm the bit count
            if (s_r.eomPulse) begin
                s_nxt.bitCnt = 6'h00;
                if (wordOk && !s_r.bufFull) begin
                    s_nxt.bufWord = s_r.shiftReg;
                    s_nxt.bufFull = 1'b1;
                end else if (wordOk) begin
                    s_nxt.heldValid = 1'b1;
                end
                if ((s_r.bitCnt == arx_pkg::WORD_BITS) && labelOk && !parityOk &&
                    selfTestParityEn) begin
                    s_nxt.control[arx_pkg::CTL_WRONG_PAR] = 1'b1;
                end
            end else if (s_r.heldValid && !s_r.bufFull && !bitRise) begin
                s_nxt.bufWord   = s_r.shiftReg;
                s_nxt.bufFull   = 1'b1;
                s_nxt.heldValid = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_r          <= '0;
            s_r.control  <= arx_pkg::CTL_RESET;
            s_r.gapValue <= arx_pkg::GAP_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // label matrix: host writes land only in programming mode
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < 256; i++) begin
                labelMatrix[i] <= 1'b0;
            end
        end else if (s_r.wrPend && matrixHit &&
                     s_r.control[arx_pkg::CTL_MATRIX_WE]) begin
            labelMatrix[accLabel] <= hwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs: one wait state on reads, none on writes, always OKAY
    assign hrdata    = s_r.rdData;
    assign hreadyout = ~s_r.rdPend;
    assign hresp     = 1'b0;
    // a parity-only failure also requests service when flagged
    assign receiveInterruptRequest = interruptEnable &
        (s_r.bufFull | s_r.control[arx_pkg::CTL_WRONG_PAR]);
    assign wordPending     = s_r.bufFull;
    assign channelPriority = s_r.control[arx_pkg::CTL_PRIO_LSB +: arx_pkg::CTL_PRIO_W];

    ////////////////////////////////////////////////////////////////////////
    // checks
    accept_load_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        s_r.eomPulse && wordOk && !s_r.bufFull && s_r.control[arx_pkg::CTL_ENABLE]
        |=> s_r.bufFull && (s_r.bufWord == $past(s_r.shiftReg)))
        else $error("accepted word not loaded into buffer");

    reject_count_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        s_r.eomPulse && (s_r.bitCnt != arx_pkg::WORD_BITS) && !s_r.heldValid
        |=> $stable(s_r.bufWord) && (s_r.bitCnt <= 6'h01))
        else $error("short or long word reached the buffer");

    gap_clear_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        bitFall && s_r.control[arx_pkg::CTL_ENABLE] |=> s_r.gapCnt == 16'h0000 && s_r.gapRun)
        else $error("gap counter not cleared after bit");

    gap_halt_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        $rose(s_r.eomPulse) |-> !s_r.gapRun && (s_r.gapCnt == s_r.gapValue) ##1 !s_r.eomPulse)
        else $error("end of message without gap match");

    lsw_free_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        s_r.rdPend && (s_r.accAddr == arx_pkg::OFS_BUF_LSW) && !s_r.eomPulse && !s_r.heldValid
        |=> !s_r.bufFull)
        else $error("lower half read did not free buffer");

    wrong_parity_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        s_r.eomPulse && s_r.control[arx_pkg::CTL_ENABLE] &&
        (s_r.bitCnt == arx_pkg::WORD_BITS) && labelOk && !parityOk && selfTestParityEn
        |=> s_r.control[arx_pkg::CTL_WRONG_PAR] && !$rose(s_r.bufFull))
        else $error("bad parity not flagged or word kept");

    held_move_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        s_r.heldValid && !s_r.bufFull && !s_r.eomPulse && !bitRise &&
        s_r.control[arx_pkg::CTL_ENABLE] |=> s_r.bufFull ##1 !s_r.heldValid)
        else $error("held word not moved once buffer freed");

    out_service_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        !s_r.control[arx_pkg::CTL_ENABLE] |=> s_r.bitCnt == 6'h00 && !s_r.eomPulse)
        else $error("disabled channel kept framing");

    irq_raise_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        $rose(s_r.bufFull) && interruptEnable |-> receiveInterruptRequest)
        else $error("interrupt missing after load");

endmodule : arx_receive_channel

// ### arx_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module arx_sync2 #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             srst,
    // asynchronous input and its synchronised copy
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } arx_sync_t;

    arx_sync_t s_r;
    arx_sync_t s_nxt;

    // first stage feeds only the second stage
    always_comb begin
        s_nxt.meta   = asyncIn;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign syncOut = s_r.stable;

endmodule : arx_sync2
